// ===== clktd_pkg.sv
/*
 * clktd_pkg: constants and types shared by the clock trim, divider and
 * failure detector block.
 * assumes a byte-wide register port and one system clock for all logic.
 */
package clktd_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] OSC_TRIM_OFS    = 8'h66;
   localparam logic [7:0] CLK_DIV_OFS     = 8'h61;
   localparam logic [7:0] FAIL_STATUS_OFS = 8'h62;

   // ==========================================================
   // field positions
   localparam int TRIM_RANGE_BIT   = 7;
   localparam int DIV_UNLOCK_BIT   = 7;
   localparam int FAIL_FLAG_BIT    = 1;
   localparam int FAIL_IRQ_EN_BIT  = 0;

   // ==========================================================
   // values and counts
   localparam logic [7:0] DIV_UNLOCK_KEY   = 8'h80;
   localparam logic [3:0] DIV_SEL_DIV1     = 4'h0;
   localparam logic [3:0] DIV_SEL_DIV8     = 4'h3;
   localparam logic [3:0] DIV_SEL_MAX      = 4'h8;
   localparam logic [3:0] SAFE_CLK_SRC     = 4'h2;
   localparam logic [2:0] UNLOCK_CYCLES    = 3'h4;
   localparam int         FAIL_TICKS       = 4;
   localparam int         STARTUP_TICKS    = 16;

   // ==========================================================
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } clktd_bus_req_s;

   typedef enum logic [1:0] {
      DET_OFF,
      DET_BLANK,
      DET_WATCH,
      DET_FAILED
   } clktd_det_e;

endpackage : clktd_pkg

// ===== clktd_div.sv
/*
 * clktd_div: power-of-two divider producing a one-cycle clock enable.
 * assumes the source clock is clk_i; a new setting is adopted only at
 * the end of the running period so no short period is ever produced.
 */
`timescale 1ns/1ns
module clktd_div (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] sel_i,
   output logic            tick_o
);

   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [3:0] act_sel;
   logic [3:0] next_act_sel;
   logic       next_tick;

   function automatic logic [7:0] clktd_last(input logic [3:0] s);
      logic [3:0] c;
      c = (s > clktd_pkg::DIV_SEL_MAX) ? clktd_pkg::DIV_SEL_MAX : s;
      clktd_last = 8'(((9'h001 << c) - 9'h001));
   endfunction : clktd_last

   // ==========================================================
   // period counter
   always_comb begin
      next_cnt     = cnt + 8'h01;
      next_act_sel = act_sel;
      next_tick    = 1'b0;
      if (cnt >= clktd_last(act_sel)) begin
         next_cnt     = 8'h00;
         next_tick    = 1'b1;
         next_act_sel = sel_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt     <= 8'h00;
         act_sel <= sel_i;
         tick_o  <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         act_sel <= next_act_sel;
         tick_o  <= next_tick;
      end
   end

endmodule : clktd_div

// ===== clktd_top.sv
/*
 * clktd_top: oscillator trim register, guarded system clock divider and
 * external oscillator failure detector with fallback to the RC clock.
 * assumes all inputs synchronous to clk_i; the 128kHz oscillator is seen
 * as a one-cycle tick, the external oscillator as a sampled level.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module clktd_top #(
   parameter int FAIL_TICKS    = clktd_pkg::FAIL_TICKS,
   parameter int STARTUP_TICKS = clktd_pkg::STARTUP_TICKS
) (
   input  wire logic                      clk_i,
   input  wire logic                      resetn_i,
   input  wire clktd_pkg::clktd_bus_req_s bus_i,
   output logic [7:0]                     rdata_o,
   input  wire logic [7:0]                factory_trim_i,
   input  wire logic                      div8_default_fuse_i,
   input  wire logic                      fail_detect_fuse_i,
   input  wire logic                      xosc_clk_i,
   input  wire logic                      lfosc_tick_i,
   input  wire logic                      deep_sleep_i,
   output logic [7:0]                     osc_trim_o,
   output logic                           sys_clk_en_o,
   output logic                           lfosc_enable_o,
   output logic                           rc_fallback_en_o,
   output logic                           safe_clk_sel_o,
   output logic [3:0]                     clk_src_code_o,
   output logic                           fail_irq_o
);

   localparam int CW = 8;

   // ==========================================================
   // state
   logic [7:0]            trim;
   logic [7:0]            next_trim;
   logic [3:0]            div_select;
   logic [3:0]            next_div_select;
   logic                  div_change_unlock;
   logic                  next_div_change_unlock;
   logic [2:0]            unlock_cnt;
   logic [2:0]            next_unlock_cnt;
   logic                  fail_flag;
   logic                  next_fail_flag;
   logic                  fail_irq_enable;
   logic                  next_fail_irq_enable;
   logic [7:0]            next_rdata;
   clktd_pkg::clktd_det_e det;
   clktd_pkg::clktd_det_e next_det;
   logic [CW-1:0]         tick_cnt;
   logic [CW-1:0]         next_tick_cnt;
   logic                  xosc_q;
   logic                  next_xosc_q;
   logic                  xosc_moved;
   logic [7:0]            next_osc_trim;
   logic                  next_lfosc_enable;
   logic                  next_rc_fallback_en;
   logic                  next_safe_clk_sel;
   logic [3:0]            next_clk_src_code;
   logic                  next_fail_irq;
   logic                  det_failing;
   logic                  wr_trim;
   logic                  wr_div;
   logic                  wr_fail;

   function automatic logic clktd_hit(input logic [7:0] a,
                                      input logic [7:0] o);
      clktd_hit = (a == o);
   endfunction : clktd_hit

   assign wr_trim = bus_i.wr && clktd_hit(bus_i.addr,
                                          clktd_pkg::OSC_TRIM_OFS);
   assign wr_div  = bus_i.wr && clktd_hit(bus_i.addr,
                                          clktd_pkg::CLK_DIV_OFS);
   assign wr_fail = bus_i.wr && clktd_hit(bus_i.addr,
                                          clktd_pkg::FAIL_STATUS_OFS);

   // ==========================================================
   // oscillator trim, reloaded with the factory value in reset
   always_comb begin
      next_trim = trim;
      if (wr_trim) begin
         next_trim = bus_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         trim <= factory_trim_i;
      end else begin
         trim <= next_trim;
      end
   end

   // ==========================================================
   // divider select behind the timed unlock sequence
   always_comb begin
      next_div_select        = div_select;
      next_div_change_unlock = div_change_unlock;
      next_unlock_cnt        = unlock_cnt;
      // unlock window counts down and closes by itself
      if (div_change_unlock) begin
         next_unlock_cnt = unlock_cnt - 3'h1;
         if (unlock_cnt == 3'h1) begin
            next_div_change_unlock = 1'b0;
         end
      end
      // only the bare key opens the window; a repeat inside it is ignored
      if (wr_div) begin
         if (bus_i.wdata == clktd_pkg::DIV_UNLOCK_KEY) begin
            if (!div_change_unlock) begin
               next_div_change_unlock = 1'b1;
               next_unlock_cnt        = clktd_pkg::UNLOCK_CYCLES;
            end
         end else if (!bus_i.wdata[clktd_pkg::DIV_UNLOCK_BIT]
                      && div_change_unlock) begin
            next_div_select        = bus_i.wdata[3:0];
            next_div_change_unlock = 1'b0;
            next_unlock_cnt        = 3'h0;
         end
      end
      // failure forces RC/8 so the fallback runs at 1MHz
      if (det_failing) begin
         next_div_select = clktd_pkg::DIV_SEL_DIV8;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         div_select        <= div8_default_fuse_i ?
                              clktd_pkg::DIV_SEL_DIV8 :
                              clktd_pkg::DIV_SEL_DIV1;
         div_change_unlock <= 1'b0;
         unlock_cnt        <= 3'h0;
      end else begin
         div_select        <= next_div_select;
         div_change_unlock <= next_div_change_unlock;
         unlock_cnt        <= next_unlock_cnt;
      end
   end

   // ==========================================================
   // failure interrupt enable, set-only
   always_comb begin
      next_fail_irq_enable = fail_irq_enable;
      if (wr_fail && bus_i.wdata[clktd_pkg::FAIL_IRQ_EN_BIT]) begin
         next_fail_irq_enable = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fail_irq_enable <= 1'b0;
      end else begin
         fail_irq_enable <= next_fail_irq_enable;
      end
   end

   // ==========================================================
   // read port
   always_comb begin
      next_rdata = 8'h00;
      if (bus_i.rd) begin
         if (clktd_hit(bus_i.addr, clktd_pkg::OSC_TRIM_OFS)) begin
            next_rdata = trim;
         end else if (clktd_hit(bus_i.addr, clktd_pkg::CLK_DIV_OFS)) begin
            next_rdata[clktd_pkg::DIV_UNLOCK_BIT] = div_change_unlock;
            next_rdata[3:0]                       = div_select;
         end else if (clktd_hit(bus_i.addr,
                                clktd_pkg::FAIL_STATUS_OFS)) begin
            next_rdata[clktd_pkg::FAIL_FLAG_BIT]   = fail_flag;
            next_rdata[clktd_pkg::FAIL_IRQ_EN_BIT] = fail_irq_enable;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ==========================================================
   // failure detector, timed by the 128kHz tick
   // a failure needs FAIL_TICKS slow ticks with the level held; any
   // change of the oscillator level restarts the count
   assign xosc_moved  = xosc_clk_i ^ xosc_q;
   assign det_failing = (det == clktd_pkg::DET_WATCH) && lfosc_tick_i
                        && (tick_cnt >= CW'(FAIL_TICKS - 1))
                        && !xosc_moved;

   always_comb begin
      next_det      = det;
      next_tick_cnt = tick_cnt;
      unique case (det)
         clktd_pkg::DET_OFF: begin
            next_tick_cnt = '0;
            if (fail_detect_fuse_i && !deep_sleep_i) begin
               next_det = clktd_pkg::DET_BLANK;
            end
         end
         clktd_pkg::DET_BLANK: begin
            if (lfosc_tick_i) begin
               next_tick_cnt = tick_cnt + CW'(1);
            end
            if (lfosc_tick_i
                && tick_cnt >= CW'(STARTUP_TICKS - 1)) begin
               next_det      = clktd_pkg::DET_WATCH;
               next_tick_cnt = '0;
            end
         end
         clktd_pkg::DET_WATCH: begin
            if (xosc_moved) begin
               next_tick_cnt = '0;
            end else if (lfosc_tick_i) begin
               next_tick_cnt = tick_cnt + CW'(1);
            end
            if (det_failing) begin
               next_det = clktd_pkg::DET_FAILED;
            end
         end
         clktd_pkg::DET_FAILED: begin
            next_det = clktd_pkg::DET_FAILED;
         end
      endcase
      if (deep_sleep_i && det != clktd_pkg::DET_FAILED) begin
         next_det      = clktd_pkg::DET_OFF;
         next_tick_cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         det      <= clktd_pkg::DET_OFF;
         tick_cnt <= '0;
      end else begin
         det      <= next_det;
         tick_cnt <= next_tick_cnt;
      end
   end

   // ==========================================================
   // failure flag, set by the detector and cleared only by reset
   always_comb begin
      next_fail_flag = fail_flag;
      if (det_failing) begin
         next_fail_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fail_flag <= 1'b0;
      end else begin
         fail_flag <= next_fail_flag;
      end
   end

   // ==========================================================
   // oscillator level one cycle old, so any change counts as activity
   always_comb begin
      next_xosc_q = xosc_clk_i;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         xosc_q <= 1'b0;
      end else begin
         xosc_q <= next_xosc_q;
      end
   end

   // ==========================================================
   // outputs
   always_comb begin
      next_osc_trim       = trim;
      next_lfosc_enable   = fail_detect_fuse_i && !deep_sleep_i;
      next_rc_fallback_en = fail_flag;
      next_safe_clk_sel   = fail_flag;
      if (fail_flag) begin
         next_clk_src_code = clktd_pkg::SAFE_CLK_SRC;
      end else begin
         next_clk_src_code = 4'h0;
      end
      next_fail_irq       = fail_flag && fail_irq_enable;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         osc_trim_o       <= 8'h00;
         lfosc_enable_o   <= 1'b0;
         rc_fallback_en_o <= 1'b0;
         safe_clk_sel_o   <= 1'b0;
         clk_src_code_o   <= 4'h0;
         fail_irq_o       <= 1'b0;
      end else begin
         osc_trim_o       <= next_osc_trim;
         lfosc_enable_o   <= next_lfosc_enable;
         rc_fallback_en_o <= next_rc_fallback_en;
         safe_clk_sel_o   <= next_safe_clk_sel;
         clk_src_code_o   <= next_clk_src_code;
         fail_irq_o       <= next_fail_irq;
      end
   end

   clktd_div u_div (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .sel_i    (div_select),
      .tick_o   (sys_clk_en_o)
   );

endmodule : clktd_top

// ===== clktd_checker.sv
/*
 * clktd_checker: port-level assertions for the clock trim, divider and
 * failure detector block.
 * assumes one clock domain and the synchronous active-low reset.
 */
`timescale 1ns/1ns
module clktd_checker (
   input wire logic                      clk_i,
   input wire logic                      resetn_i,
   input wire clktd_pkg::clktd_bus_req_s bus_i,
   input wire logic [7:0]                rdata_o,
   input wire logic                      fail_detect_fuse_i,
   input wire logic                      deep_sleep_i,
   input wire logic [7:0]                osc_trim_o,
   input wire logic                      lfosc_enable_o,
   input wire logic                      rc_fallback_en_o,
   input wire logic                      safe_clk_sel_o,
   input wire logic [3:0]                clk_src_code_o,
   input wire logic                      fail_irq_o
);
   // ==========================================================
   // assertions
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_RDATA_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data not idle");
   AST_STATUS_RSVD: assert property ($past(bus_i.rd &&
      bus_i.addr == clktd_pkg::FAIL_STATUS_OFS) |-> rdata_o[7:2] == 6'h00)
      else $error("status upper bits not zero");
   AST_SRC_CODE: assert property (clk_src_code_o ==
      (safe_clk_sel_o ? clktd_pkg::SAFE_CLK_SRC : 4'h0))
      else $error("clock source code wrong");
   AST_RC_OFF: assert property (rc_fallback_en_o == safe_clk_sel_o)
      else $error("fallback enable mismatch");
   AST_FAIL_STICKY: assert property (safe_clk_sel_o |=> safe_clk_sel_o)
      else $error("fallback left without reset");
   AST_IRQ_FLAG: assert property (fail_irq_o |-> safe_clk_sel_o)
      else $error("interrupt without failure");
   AST_IRQ_HOLD: assert property (fail_irq_o |=> fail_irq_o)
      else $error("interrupt dropped");
   AST_LF_EN: assert property ($past(resetn_i) |-> lfosc_enable_o ==
      $past(fail_detect_fuse_i && !deep_sleep_i))
      else $error("slow oscillator enable wrong");
   AST_TRIM_FOLLOW: assert property ($past(resetn_i, 2) &&
      $past(resetn_i) && $past(bus_i.wr && bus_i.addr ==
      clktd_pkg::OSC_TRIM_OFS, 2) |-> osc_trim_o == $past(bus_i.wdata, 2))
      else $error("trim output did not follow write");
endmodule : clktd_checker

bind clktd_top clktd_checker u_chk (.clk_i, .resetn_i, .bus_i, .rdata_o,
   .fail_detect_fuse_i, .deep_sleep_i, .osc_trim_o, .lfosc_enable_o,
   .rc_fallback_en_o, .safe_clk_sel_o, .clk_src_code_o, .fail_irq_o);

// ===== clktd_xosc_model.sv
/*
 * clktd_xosc_model: external oscillator and 128kHz tick source.
 * assumes clk_i is the system clock; a stopped oscillator holds its level.
 */
`timescale 1ns/1ns
module clktd_xosc_model #(
   parameter int HALF  = 2,
   parameter int LFDIV = 4
) (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic lf_en_i,
   output logic      xosc_clk_o,
   output logic      lfosc_tick_o
);
   int hc = 0;
   int lc = 0;
   initial begin
      xosc_clk_o = 1'b0;
      lfosc_tick_o = 1'b0;
   end
   always @(posedge clk_i) begin
      hc <= (hc + 1) % HALF;
      lc <= (lc + 1) % LFDIV;
      if (run_i && hc == 0) begin
         xosc_clk_o <= !xosc_clk_o;
      end
      lfosc_tick_o <= lf_en_i && lc == 0;
   end
endmodule : clktd_xosc_model

// ===== tb_clktd_top.sv
/*
 * tb_clktd_top: register-level tests of trim, divider and failure detect.
 * assumes the checker is bound to clktd_top and the oscillator model file.
 */
`timescale 1ns/1ns
module tb_clktd_top;
   localparam logic [7:0] TRIM = clktd_pkg::OSC_TRIM_OFS;
   localparam logic [7:0] DIV  = clktd_pkg::CLK_DIV_OFS;
   localparam logic [7:0] STAT = clktd_pkg::FAIL_STATUS_OFS;
   logic clk_i = 1'b0;
   logic resetn_i, div8, fuse, sleep, run, xosc, lft, lfen, safe, rcen, irq;
   logic sysen;
   logic [7:0] rdata, trim_f, trim_o;
   logic [3:0] src;
   clktd_pkg::clktd_bus_req_s bus;
   int n_errors = 0;
   int compares = 0;

   always #4 clk_i = !clk_i;

   clktd_top #(.FAIL_TICKS(2), .STARTUP_TICKS(2)) dut_u (
      .clk_i, .resetn_i, .bus_i(bus), .rdata_o(rdata),
      .factory_trim_i(trim_f), .div8_default_fuse_i(div8),
      .fail_detect_fuse_i(fuse), .xosc_clk_i(xosc), .lfosc_tick_i(lft),
      .deep_sleep_i(sleep), .osc_trim_o(trim_o), .sys_clk_en_o(sysen),
      .lfosc_enable_o(lfen), .rc_fallback_en_o(rcen),
      .safe_clk_sel_o(safe), .clk_src_code_o(src), .fail_irq_o(irq));
   clktd_xosc_model xm_u (.clk_i, .run_i(run), .lf_en_i(lfen),
      .xosc_clk_o(xosc), .lfosc_tick_o(lft));

   // ==========================================================
   // access tasks
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus <= '0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus <= '0;
      @(negedge clk_i);
      chk(rdata, exp);
      @(posedge clk_i);
   endtask : rd
   task automatic meas(input logic [8:0] p);
      int n;
      repeat (3) begin
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (sysen !== 1'b1 && n < 600);
      end
      chk(9'(n), p);
      @(posedge clk_i);
   endtask : meas
   task automatic tally_and_finish;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // tests
   initial begin
      #400000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      bus = '0;
      resetn_i = 1'b0;
      trim_f = 8'hA5;
      div8 = 1'b1;
      fuse = 1'b1;
      sleep = 1'b0;
      run = 1'b1;
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rd(TRIM, 8'hA5);
      chk(trim_o, 9'h0A5);
      rd(DIV, 8'h03);
      rd(STAT, 8'h00);
      rd(8'h10, 8'h00);
      wr(TRIM, 8'h7F);
      rd(TRIM, 8'h7F);
      chk(trim_o, 9'h07F);
      wr(TRIM, 8'h80);
      rd(TRIM, 8'h80);
      chk(trim_o, 9'h080);
      wr(DIV, 8'h81);
      wr(DIV, 8'h02);
      rd(DIV, 8'h03);
      wr(DIV, 8'h80);
      wr(DIV, 8'h80);
      @(posedge clk_i);
      wr(DIV, 8'h02);
      rd(DIV, 8'h03);
      wr(DIV, 8'h80);
      wr(DIV, 8'h06);
      rd(DIV, 8'h06);
      for (int c = 0; c < 10; c++) begin
         wr(DIV, 8'h80);
         wr(DIV, 8'(c));
         meas((c > 8) ? 9'h100 : 9'(1 << c));
      end
      $display("registers and divider done");
      wr(STAT, 8'h01);
      wr(STAT, 8'h02);
      rd(STAT, 8'h01);
      chk(lfen, 9'h001);
      repeat (100) @(posedge clk_i);
      chk(safe, 9'h000);
      chk(rcen, 9'h000);
      sleep <= 1'b1;
      run <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk(lfen, 9'h000);
      chk(safe, 9'h000);
      sleep <= 1'b0;
      repeat (11) @(posedge clk_i);
      chk(safe, 9'h000);
      repeat (60) @(posedge clk_i);
      chk(safe, 9'h001);
      chk(rcen, 9'h001);
      chk(src, 9'h002);
      chk(irq, 9'h001);
      wr(STAT, 8'h00);
      rd(STAT, 8'h03);
      rd(DIV, 8'h03);
      meas(9'h008);
      run <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk(safe, 9'h001);
      $display("failure detect done");
      div8 <= 1'b0;
      resetn_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rd(STAT, 8'h00);
      rd(DIV, 8'h00);
      rd(TRIM, 8'hA5);
      chk(safe, 9'h000);
      meas(9'h001);
      $display("second reset done");
      tally_and_finish();
   end
endmodule : tb_clktd_top
